// *** design/fcoc_device.sv ***
// Flash command sequencer, mode control registers and option byte
`timescale 1ns/100ps
`include "fcoc_defs.svh"
module fcoc_device #(
  parameter logic [7:0] OPTION_BYTE = `FCOC_OPTION_DEF,
  parameter int PROG_CYCLES = `FCOC_PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Processor bus
  fcoc_if.dev bus,
  // Array write port
  output logic prog_stb,
  output logic [23:0] prog_addr,
  output logic [31:0] prog_data,
  output logic blank_stb,
  output logic [23:0] blank_addr,
  output logic busy,
  // Processor wait input, mode and option outputs
  input wire logic proc_wait,
  output logic df_one_wait,
  output logic user_boot_sel,
  output logic [7:0] guarded_cfg,
  output logic [7:0] mode2_cfg,
  output logic code_protect,
  output logic vmon0_reset_en,
  output logic wdt_csp_en
);
  fcoc_pkg::fcoc_seq_t st_ff, nxt_st;
  logic [23:0] wa_ff, nxt_wa;
  logic [15:0] lo_ff, nxt_lo;
  logic [31:0] pd_ff, nxt_pd;
  logic [2:0] cnt_ff, nxt_cnt;
  logic pstb_ff, nxt_pstb, bstb_ff, nxt_bstb;
  logic [23:0] ba_ff, nxt_ba;
  logic [7:0] m0_ff, nxt_m0, m1_ff, nxt_m1, m2_ff, nxt_m2, g_ff, nxt_g;
  logic [15:0] rd_ff, nxt_rd;
  logic [7:0] code;
  logic reg_hit, user_even;

  assign code = bus.wdata[7:0];
  assign reg_hit = bus.addr == `FCOC_OFS_MODE0 || bus.addr == `FCOC_OFS_MODE1
    || bus.addr == `FCOC_OFS_MODE2 || bus.addr == `FCOC_OFS_GUARD
    || bus.addr == `FCOC_OFS_OPTION;
  assign user_even = !bus.addr[0] && bus.addr >= `FCOC_USER_LO;

  // Sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_wa = wa_ff;
    nxt_lo = lo_ff;
    nxt_pd = pd_ff;
    nxt_cnt = cnt_ff;
    nxt_pstb = 1'b0;
    nxt_bstb = 1'b0;
    nxt_ba = ba_ff;
    case (st_ff)
      fcoc_pkg::FCOC_IDLE: begin
        if (bus.wr && !reg_hit) begin
          // Misaligned or odd address: command never starts
          if (code == `FCOC_CMD_PROGRAM && bus.addr[1:0] == 2'h0) begin
            nxt_st = fcoc_pkg::FCOC_PRG_LO;
            nxt_wa = bus.addr;
          end else if (code == `FCOC_CMD_BLANK && user_even) begin
            nxt_st = fcoc_pkg::FCOC_BLK_CF;
          end
        end
      end
      fcoc_pkg::FCOC_PRG_LO: begin
        if (bus.wr) begin
          if (bus.addr == wa_ff) begin
            nxt_lo = bus.wdata;
            nxt_st = fcoc_pkg::FCOC_PRG_HI;
          end else begin
            nxt_st = fcoc_pkg::FCOC_IDLE;
          end
        end
      end
      fcoc_pkg::FCOC_PRG_HI: begin
        if (bus.wr) begin
          if (bus.addr == wa_ff) begin
            nxt_pd = {bus.wdata, lo_ff};
            nxt_pstb = 1'b1;
            nxt_cnt = 3'(PROG_CYCLES);
            nxt_st = fcoc_pkg::FCOC_BUSY;
          end else begin
            nxt_st = fcoc_pkg::FCOC_IDLE;
          end
        end
      end
      fcoc_pkg::FCOC_BLK_CF: begin
        if (bus.wr) begin
          if (code == `FCOC_CMD_CONFIRM && !bus.addr[0]) begin
            nxt_ba = bus.addr;
            nxt_bstb = 1'b1;
            nxt_cnt = 3'(PROG_CYCLES);
            nxt_st = fcoc_pkg::FCOC_BUSY;
          end else begin
            nxt_st = fcoc_pkg::FCOC_IDLE;
          end
        end
      end
      fcoc_pkg::FCOC_BUSY: begin
        // Command writes while busy are dropped; array owns the cycle
        if (cnt_ff == 3'h0) begin
          nxt_st = fcoc_pkg::FCOC_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 3'h1;
        end
      end
      default: nxt_st = fcoc_pkg::FCOC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= fcoc_pkg::FCOC_IDLE;
      wa_ff <= 24'h000000;
      lo_ff <= 16'h0000;
      pd_ff <= 32'h00000000;
      cnt_ff <= 3'h0;
      pstb_ff <= 1'b0;
      bstb_ff <= 1'b0;
      ba_ff <= 24'h000000;
    end else begin
      st_ff <= nxt_st;
      wa_ff <= nxt_wa;
      lo_ff <= nxt_lo;
      pd_ff <= nxt_pd;
      cnt_ff <= nxt_cnt;
      pstb_ff <= nxt_pstb;
      bstb_ff <= nxt_bstb;
      ba_ff <= nxt_ba;
    end
  end

  // Mode registers and read port
  always_comb begin
    nxt_m0 = m0_ff;
    nxt_m1 = m1_ff;
    nxt_m2 = m2_ff;
    nxt_g = g_ff;
    nxt_rd = 16'h0000;
    if (bus.wr) begin
      case (bus.addr)
        `FCOC_OFS_MODE0: nxt_m0 = code;
        `FCOC_OFS_MODE1: nxt_m1 = code;
        `FCOC_OFS_MODE2: nxt_m2 = code;
        `FCOC_OFS_GUARD: begin
          if (m1_ff[`FCOC_BIT_GUARD_WE]) begin
            nxt_g = code;
          end
        end
        default: nxt_g = g_ff;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        `FCOC_OFS_MODE0: nxt_rd = {8'h00, m0_ff};
        `FCOC_OFS_MODE1: nxt_rd = {8'h00, m1_ff};
        `FCOC_OFS_MODE2: nxt_rd = {8'h00, m2_ff};
        `FCOC_OFS_GUARD: nxt_rd = {8'h00, g_ff};
        `FCOC_OFS_OPTION: nxt_rd = {8'h00, OPTION_BYTE};
        default: nxt_rd = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m0_ff <= `FCOC_MODE0_RST;
      m1_ff <= `FCOC_MODE1_RST;
      m2_ff <= `FCOC_MODE2_RST;
      g_ff <= `FCOC_GUARD_RST;
      rd_ff <= 16'h0000;
    end else begin
      m0_ff <= nxt_m0;
      m1_ff <= nxt_m1;
      m2_ff <= nxt_m2;
      g_ff <= nxt_g;
      rd_ff <= nxt_rd;
    end
  end

  assign bus.rdata = rd_ff;
  assign prog_stb = pstb_ff;
  assign prog_addr = wa_ff;
  assign prog_data = pd_ff;
  assign blank_stb = bstb_ff;
  assign blank_addr = ba_ff;
  assign busy = st_ff == fcoc_pkg::FCOC_BUSY;
  assign user_boot_sel = m0_ff[`FCOC_BIT_USERBOOT];
  assign guarded_cfg = g_ff;
  assign mode2_cfg = m2_ff;
  // Data flash wait: fixed one wait, or follow processor setting
  assign df_one_wait = m1_ff[`FCOC_BIT_DF_WAIT] ? proc_wait : 1'b1;
  // Option byte is fixed at build; it cannot change under software
  assign code_protect = OPTION_BYTE[`FCOC_BIT_CP_CANCEL]
    && !OPTION_BYTE[`FCOC_BIT_CP];
  assign vmon0_reset_en = !OPTION_BYTE[`FCOC_BIT_VMON0];
  assign wdt_csp_en = !OPTION_BYTE[`FCOC_BIT_WDT_CSP];
endmodule

// *** design/fcoc_host.sv ***
// Bus master issuing flash command sequences and register accesses
`timescale 1ns/100ps
`include "fcoc_defs.svh"
module fcoc_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software port
  input wire logic [23:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Processor bus
  fcoc_if.host bus
);
  fcoc_pkg::fcoc_host_t st_ff, nxt_st;
  logic [23:0] wa_ff, nxt_wa;
  logic [15:0] lo_ff, nxt_lo, hi_ff, nxt_hi;
  logic [1:0] ph_ff, nxt_ph;
  logic blank_ff, nxt_blank;
  logic [23:0] a_ff, nxt_a;
  logic [15:0] d_ff, nxt_d, r_ff, nxt_r;
  logic w_ff, nxt_w, rs_ff, nxt_rs, rv_ff, nxt_rv;
  // Bus read data lands one cycle after the bus strobe
  logic rb_ff, nxt_rb;

  always_comb begin
    nxt_st = st_ff;
    nxt_wa = wa_ff;
    nxt_lo = lo_ff;
    nxt_hi = hi_ff;
    nxt_ph = ph_ff;
    nxt_blank = blank_ff;
    nxt_a = sw_addr;
    nxt_d = sw_wdata;
    nxt_w = 1'b0;
    nxt_rs = 1'b0;
    nxt_rv = 1'b0;
    nxt_rb = rs_ff;
    nxt_r = r_ff;
    case (st_ff)
      fcoc_pkg::FCOC_H_IDLE: begin
        if (sw_wr && sw_addr == `FCOC_OFS_ADDR) begin
          nxt_wa = {wa_ff[23:16], sw_wdata};
        end else if (sw_wr && sw_addr == `FCOC_OFS_CMD) begin
          nxt_wa = {sw_wdata[7:0], wa_ff[15:0]};
        end else if (sw_wr && sw_addr == `FCOC_OFS_DATA) begin
          nxt_lo = hi_ff;
          nxt_hi = sw_wdata;
        end else if (sw_wr && sw_addr == `FCOC_OFS_GO) begin
          nxt_blank = sw_wdata[0];
          nxt_ph = 2'h0;
          nxt_st = fcoc_pkg::FCOC_H_WR;
        end else if (sw_wr) begin
          nxt_w = 1'b1;
        end else if (sw_rd && sw_addr == `FCOC_OFS_STAT) begin
          nxt_rv = 1'b1;
          nxt_r = 16'h0000;
        end else if (sw_rd) begin
          nxt_rs = 1'b1;
          nxt_st = fcoc_pkg::FCOC_H_WAIT;
        end
      end
      fcoc_pkg::FCOC_H_WR: begin
        nxt_w = 1'b1;
        nxt_a = blank_ff && ph_ff == 2'h0 ? {wa_ff[23:2], 2'h0} : wa_ff;
        if (!blank_ff) begin
          nxt_a = {wa_ff[23:2], 2'h0};
        end
        case (ph_ff)
          2'h0: nxt_d = {8'h00, blank_ff ? `FCOC_CMD_BLANK : `FCOC_CMD_PROGRAM};
          2'h1: nxt_d = blank_ff ? {8'h00, `FCOC_CMD_CONFIRM} : lo_ff;
          default: nxt_d = hi_ff;
        endcase
        if (ph_ff == (blank_ff ? 2'h1 : 2'h2)) begin
          nxt_st = fcoc_pkg::FCOC_H_IDLE;
        end else begin
          nxt_ph = ph_ff + 2'h1;
        end
      end
      fcoc_pkg::FCOC_H_WAIT: nxt_st = fcoc_pkg::FCOC_H_IDLE;
      default: nxt_st = fcoc_pkg::FCOC_H_IDLE;
    endcase
    // Status stays readable while a sequence is in flight
    if (sw_rd && sw_addr == `FCOC_OFS_STAT) begin
      nxt_rv = 1'b1;
    end
    if (rv_ff) begin
      nxt_r = {15'h0000, st_ff != fcoc_pkg::FCOC_H_IDLE};
    end else if (rb_ff) begin
      nxt_r = bus.rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= fcoc_pkg::FCOC_H_IDLE;
      wa_ff <= 24'h000000;
      lo_ff <= 16'h0000;
      hi_ff <= 16'h0000;
      ph_ff <= 2'h0;
      blank_ff <= 1'b0;
      a_ff <= 24'h000000;
      d_ff <= 16'h0000;
      r_ff <= 16'h0000;
      w_ff <= 1'b0;
      rs_ff <= 1'b0;
      rv_ff <= 1'b0;
      rb_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      wa_ff <= nxt_wa;
      lo_ff <= nxt_lo;
      hi_ff <= nxt_hi;
      ph_ff <= nxt_ph;
      blank_ff <= nxt_blank;
      a_ff <= nxt_a;
      d_ff <= nxt_d;
      r_ff <= nxt_r;
      w_ff <= nxt_w;
      rs_ff <= nxt_rs;
      rv_ff <= nxt_rv;
      rb_ff <= nxt_rb;
    end
  end

  assign bus.addr = a_ff;
  assign bus.wdata = d_ff;
  assign bus.wr = w_ff;
  assign bus.rd = rs_ff;
  assign sw_rdata = r_ff;
endmodule

// *** dv/fcoc_monitor.sv ***
// Concurrent checks on the flash sequencer bus and its outputs
`timescale 1ns/100ps
module fcoc_monitor #(
  parameter logic [7:0] OPTION_BYTE = 8'hff,
  parameter int PROG_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Processor bus
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  // Sequencer outputs
  input wire logic prog_stb,
  input wire logic [23:0] prog_addr,
  input wire logic [31:0] prog_data,
  input wire logic blank_stb,
  input wire logic [23:0] blank_addr,
  input wire logic busy,
  // Mode and option outputs
  input wire logic [7:0] guarded_cfg,
  input wire logic user_boot_sel,
  input wire logic code_protect,
  input wire logic vmon0_reset_en,
  input wire logic wdt_csp_en
);
  logic [3:0] busy_cnt_ff;
  logic [3:0] nxt_busy_cnt;
  // Length of the current busy stretch
  always_comb nxt_busy_cnt = busy ? busy_cnt_ff + 4'h1 : 4'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_cnt_ff <= 4'h0;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Only back-to-back sequences are covered; the bench drives no spaced ones either
  sequence s_prog_cmd;
    wr && wdata[7:0] == 8'h41 && addr[1:0] == 2'h0 && !busy;
  endsequence
  sequence s_prog_rest;
    (wr && $stable(addr)) [*2];
  endsequence
  sequence s_blank_cmd;
    wr && wdata[7:0] == 8'h25 && !addr[0] && addr >= 24'h010000 && !busy;
  endsequence
  property p_prog;
    s_prog_cmd ##1 s_prog_rest |=> prog_stb && prog_addr == $past(addr)
      && prog_data == {$past(wdata), $past(wdata, 2)};
  endproperty
  a_prog: assert property (p_prog)
    else $error("program strobe, address or data wrong");
  property p_misalign;
    (wr && wdata[7:0] == 8'h41 && addr[1:0] != 2'h0 && !busy) ##1 wr [*2] |=> !prog_stb;
  endproperty
  a_misalign: assert property (p_misalign)
    else $error("misaligned program was accepted");
  property p_blank;
    s_blank_cmd ##1 (wr && wdata[7:0] == 8'hd0 && !addr[0]) |=>
      blank_stb && blank_addr == $past(addr);
  endproperty
  a_blank: assert property (p_blank)
    else $error("blank check not started");
  property p_blank_abort;
    s_blank_cmd ##1 (wr && wdata[7:0] != 8'hd0) |=> !blank_stb;
  endproperty
  a_blank_abort: assert property (p_blank_abort)
    else $error("blank check ran without confirm");
  property p_busy_len;
    $fell(busy) |-> busy_cnt_ff == 4'(PROG_CYCLES + 1);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  property p_guard;
    $changed(guarded_cfg) |-> $past(wr) && $past(addr) == 24'h000230;
  endproperty
  a_guard: assert property (p_guard)
    else $error("guarded register changed without a write");
  property p_boot;
    $changed(user_boot_sel) |-> $past(wr) && $past(addr) == 24'h000220;
  endproperty
  a_boot: assert property (p_boot)
    else $error("user boot select changed without a write");
  property p_opt;
    code_protect == (OPTION_BYTE[2] && !OPTION_BYTE[3]) && vmon0_reset_en == !OPTION_BYTE[6]
      && wdt_csp_en == !OPTION_BYTE[7];
  endproperty
  a_opt: assert property (p_opt)
    else $error("option outputs disagree with option byte");
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for host and flash sequencer
`timescale 1ns/100ps
module testbench;
  logic clk, rst_n, sw_wr, sw_rd, proc_wait, prog_stb, blank_stb, busy;
  logic [23:0] sw_addr, prog_addr, blank_addr;
  logic [15:0] sw_wdata, sw_rdata;
  logic [31:0] prog_data;
  logic [7:0] guarded_cfg, mode2_cfg;
  logic df_one_wait, user_boot_sel, code_protect, vmon0_reset_en, wdt_csp_en;
  logic [23:0] ba [3] = '{24'h020002, 24'h020003, 24'h000100};
  logic [15:0] bc [3] = '{16'h00d1, 16'h00d0, 16'h00d0};
  int bad_count = 0;
  int num_checks = 0;
  int prog_n = 0;
  int blank_n = 0;
  fcoc_if bus_if ();
  fcoc_device #(.OPTION_BYTE(8'h84), .PROG_CYCLES(1)) fcoc_device_i (.clk(clk), .rst_n(rst_n),
    .bus(bus_if), .prog_stb(prog_stb), .prog_addr(prog_addr), .prog_data(prog_data),
    .blank_stb(blank_stb), .blank_addr(blank_addr), .busy(busy), .proc_wait(proc_wait),
    .df_one_wait(df_one_wait), .user_boot_sel(user_boot_sel), .guarded_cfg(guarded_cfg),
    .mode2_cfg(mode2_cfg), .code_protect(code_protect), .vmon0_reset_en(vmon0_reset_en),
    .wdt_csp_en(wdt_csp_en));
  fcoc_host fcoc_host_i (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(bus_if));
  fcoc_monitor #(.OPTION_BYTE(8'h84), .PROG_CYCLES(1)) fcoc_monitor_i (.clk(clk),
    .rst_n(rst_n), .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
    .prog_stb(prog_stb), .prog_addr(prog_addr), .prog_data(prog_data),
    .blank_stb(blank_stb), .blank_addr(blank_addr), .busy(busy), .guarded_cfg(guarded_cfg),
    .user_boot_sel(user_boot_sel), .code_protect(code_protect),
    .vmon0_reset_en(vmon0_reset_en), .wdt_csp_en(wdt_csp_en));
  task close_out;
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Strobe stays high so writes may run back to back; gap lowers it
  task wr(input logic [23:0] a, input logic [15:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
  endtask
  task gap(input int n);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task rd(input logic [23:0] a, input logic [7:0] e, input string name);
    sw_addr <= a;
    sw_wr <= 1'b0;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(name, {24'h0, e}, {16'h0, sw_rdata});
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (prog_stb === 1'b1) prog_n++;
    if (blank_stb === 1'b1) blank_n++;
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    close_out;
  end
  initial begin
    rst_n = 1'b0;
    sw_addr = 24'h0;
    sw_wdata = 16'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    proc_wait = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("code_protect", 1, code_protect);
    chk("vmon0_reset_en", 1, vmon0_reset_en);
    chk("wdt_csp_en", 0, wdt_csp_en);
    rd(24'hffffff, 8'h84, "option_select_byte");
    rd(24'h000221, 8'h00, "flash_mode_ctrl1");
    rd(24'h000230, 8'h00, "flash_mode_ctrl_guarded");
    wr(24'h010004, 16'ha541);
    wr(24'h010004, 16'h1234);
    wr(24'h010004, 16'h5678);
    gap(6);
    chk("prog_n", 1, prog_n);
    chk("prog_addr", 32'h00010004, {8'h0, prog_addr});
    chk("prog_data", 32'h56781234, prog_data);
    for (int i = 0; i < 3; i++) wr(24'h010006, 16'h0041);
    gap(6);
    chk("prog_n", 1, prog_n);
    wr(24'h000302, 16'h0008);
    wr(24'h000300, 16'h0001);
    wr(24'h000303, 16'hbeef);
    wr(24'h000303, 16'hcafe);
    wr(24'h000304, 16'h0000);
    rd(24'h000301, 8'h01, "host_busy");
    gap(12);
    rd(24'h000301, 8'h00, "host_busy");
    chk("prog_addr", 32'h00010008, {8'h0, prog_addr});
    chk("prog_data", 32'hcafebeef, prog_data);
    // Third cycle at another address must abandon
    wr(24'h01000c, 16'h0041);
    wr(24'h01000c, 16'h0001);
    wr(24'h010010, 16'h0002);
    gap(6);
    chk("prog_n", 2, prog_n);
    chk("prog_data", 32'hcafebeef, prog_data);
    wr(24'h020002, 16'hff25);
    wr(24'h01fffe, 16'h33d0);
    gap(6);
    chk("blank_addr", 32'h0001fffe, {8'h0, blank_addr});
    for (int i = 0; i < 3; i++) begin
      wr(ba[i], 16'h0025);
      wr(24'h01fffe, bc[i]);
      gap(6);
    end
    chk("blank_n", 1, blank_n);
    wr(24'h000230, 16'h005a);
    gap(2);
    chk("guarded_cfg", 0, guarded_cfg);
    wr(24'h000221, 16'h0002);
    wr(24'h000230, 16'h005a);
    gap(2);
    chk("guarded_cfg", 32'h5a, guarded_cfg);
    chk("df_one_wait", 1, df_one_wait);
    wr(24'h000221, 16'h0082);
    for (int i = 0; i < 2; i++) begin
      proc_wait <= i[0];
      gap(3);
      chk("df_one_wait", i, df_one_wait);
    end
    wr(24'h000220, 16'h0020);
    gap(2);
    chk("user_boot_sel", 1, user_boot_sel);
    wr(24'h000220, 16'h0000);
    gap(2);
    chk("user_boot_sel", 0, user_boot_sel);
    wr(24'h000222, 16'h12a5);
    gap(2);
    chk("mode2_cfg", 32'ha5, mode2_cfg);
    rd(24'h000222, 8'ha5, "flash_mode_ctrl2");
    close_out;
  end
endmodule

// *** inc/fcoc_defs.svh ***
// Offsets, field positions, codes and reset values of the flash sequencer
`ifndef FCOC_DEFS_SVH
`define FCOC_DEFS_SVH
`define FCOC_ADDR_W 24
`define FCOC_OFS_MODE0 24'h000220
`define FCOC_OFS_MODE1 24'h000221
`define FCOC_OFS_MODE2 24'h000222
`define FCOC_OFS_GUARD 24'h000230
`define FCOC_OFS_OPTION 24'hffffff
`define FCOC_OFS_CMD 24'h000300
`define FCOC_OFS_STAT 24'h000301
`define FCOC_OFS_ADDR 24'h000302
`define FCOC_OFS_DATA 24'h000303
`define FCOC_OFS_GO 24'h000304
`define FCOC_CMD_PROGRAM 8'h41
`define FCOC_CMD_BLANK 8'h25
`define FCOC_CMD_CONFIRM 8'hd0
`define FCOC_USER_LO 24'h010000
`define FCOC_USER_HI 24'hffffff
`define FCOC_BIT_USERBOOT 5
`define FCOC_BIT_GUARD_WE 1
`define FCOC_BIT_DF_WAIT 7
`define FCOC_BIT_CP_CANCEL 2
`define FCOC_BIT_CP 3
`define FCOC_BIT_VMON0 6
`define FCOC_BIT_WDT_CSP 7
`define FCOC_MODE0_RST 8'h00
`define FCOC_MODE1_RST 8'h00
`define FCOC_MODE2_RST 8'h00
`define FCOC_GUARD_RST 8'h00
`define FCOC_OPTION_DEF 8'hff
`define FCOC_PROG_CYCLES 4
`endif

// *** inc/fcoc_if.sv ***
// Processor bus between flash sequencer and its master
`timescale 1ns/100ps
interface fcoc_if;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// *** inc/fcoc_pkg.sv ***
// Types shared by the flash sequencer and its bus master
package fcoc_pkg;
  typedef enum logic [2:0] {
    FCOC_IDLE = 3'h0,
    FCOC_PRG_LO = 3'h1,
    FCOC_PRG_HI = 3'h3,
    FCOC_BUSY = 3'h2,
    FCOC_BLK_CF = 3'h6
  } fcoc_seq_t;
  typedef enum logic [1:0] {
    FCOC_H_IDLE = 2'h0,
    FCOC_H_WR = 2'h1,
    FCOC_H_WAIT = 2'h3
  } fcoc_host_t;
endpackage
